/* File: design/spc_top.sv */
// Sector protection control: global protect, lock bit and protection read.
`timescale 1ns/1ps
`include "spc_map.svh"

module spc_top (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic cs_n_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    output logic so_out,
    output logic so_oe_out,
    output logic sector_lock_bit_out,
    output logic write_enable_latch_out,
    output logic [1:0] soft_protect_summary_out,
    output logic [15:0] sector_prot_out
);

    // ------------------------------------------------------------------
    // Pin synchronisation and frame reception
    // ------------------------------------------------------------------

    logic [3:0] pins_sync;
    logic sck_s;
    logic si_s;
    logic cs_n_s;
    logic wp_s;

    spc_link_if link ();

    spc_sync u_sync (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .async_in({wp_n_in, cs_n_in, si_in, sck_in}),
        .sync_out(pins_sync)
    );

    assign sck_s = pins_sync[0];
    assign si_s = pins_sync[1];
    assign cs_n_s = pins_sync[2];
    assign wp_s = pins_sync[3];

    spc_shifter u_shifter (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .sck_in(sck_s),
        .si_in(si_s),
        .cs_n_in(cs_n_s),
        .link(link.src)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    spc_pkg::spc_state_type state;
    spc_pkg::spc_state_type next_state;
    logic [7:0] opcode;
    logic [1:0] addr_cnt;
    logic [3:0] sector_idx;
    logic addr_ok;
    logic data_ok;
    logic [7:0] wr_data;
    logic [2:0] out_idx;
    logic read_status;
    logic lock;
    logic write_enable_latch;
    logic [15:0] prot;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------

    wire [7:0] rx = link.rx_byte;
    wire cmd_byte = link.byte_done & (state == spc_pkg::SPC_CMD);
    wire addr_byte = link.byte_done & (state == spc_pkg::SPC_ADDR);
    wire data_byte = link.byte_done & (state == spc_pkg::SPC_DATA);
    wire addr_last = addr_byte & (addr_cnt == `SPC_ADDR_LAST);
    wire rx_is_addr_cmd = (rx == `SPC_OP_RDPROT) | (rx == `SPC_OP_PROT) |
                          (rx == `SPC_OP_UNPROT);

    wire op_wren = (opcode == `SPC_OP_WREN) & (state == spc_pkg::SPC_SKIP);
    wire op_wrdi = (opcode == `SPC_OP_WRDI) & (state == spc_pkg::SPC_SKIP);
    wire op_wrsr = (opcode == `SPC_OP_WRSR);
    wire op_prot = (opcode == `SPC_OP_PROT);
    wire op_unprot = (opcode == `SPC_OP_UNPROT);

    wire end_evt = link.frame_end;
    wire wrsr_done = end_evt & op_wrsr & data_ok;
    wire wrsr_run = wrsr_done & write_enable_latch;
    wire hw_locked = lock & ~wp_s;
    wire wrsr_take = wrsr_run & ~hw_locked;
    wire [3:0] glb_bits = wr_data[`SPC_GLB_HI:`SPC_GLB_LO];
    wire glb_all1 = (glb_bits == `SPC_GLB_ALL1);
    wire glb_all0 = (glb_bits == `SPC_GLB_ALL0);
    wire glb_ok = wrsr_take & ~lock;
    wire glb_set = glb_ok & glb_all1;
    wire glb_clr = glb_ok & glb_all0;

    wire sect_end = end_evt & (op_prot | op_unprot);
    wire sect_run = sect_end & addr_ok & write_enable_latch & ~lock;
    wire sect_set = sect_run & op_prot;
    wire sect_clr = sect_run & op_unprot;

    wire wel_set = end_evt & op_wren;
    wire wel_clr = end_evt & (op_wrdi | wrsr_done | sect_end);

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------

    always_comb begin
        next_state = state;
        case (state)
            spc_pkg::SPC_IDLE: begin
                if (link.active) begin
                    next_state = spc_pkg::SPC_CMD;
                end
            end
            spc_pkg::SPC_CMD: begin
                if (cmd_byte) begin
                    if (rx == `SPC_OP_WRSR) begin
                        next_state = spc_pkg::SPC_DATA;
                    end else if (rx == `SPC_OP_RDSR) begin
                        next_state = spc_pkg::SPC_READ;
                    end else if (rx_is_addr_cmd) begin
                        next_state = spc_pkg::SPC_ADDR;
                    end else begin
                        next_state = spc_pkg::SPC_SKIP;
                    end
                end
            end
            spc_pkg::SPC_ADDR: begin
                if (addr_last) begin
                    if (opcode == `SPC_OP_RDPROT) begin
                        next_state = spc_pkg::SPC_READ;
                    end else begin
                        next_state = spc_pkg::SPC_SKIP;
                    end
                end
            end
            spc_pkg::SPC_DATA: begin
                if (data_byte) begin
                    next_state = spc_pkg::SPC_SKIP;
                end
            end
            spc_pkg::SPC_READ: begin
                next_state = spc_pkg::SPC_READ;
            end
            spc_pkg::SPC_SKIP: begin
                next_state = spc_pkg::SPC_SKIP;
            end
            default: begin
                next_state = spc_pkg::SPC_IDLE;
            end
        endcase
        if (!link.active) begin
            next_state = spc_pkg::SPC_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= spc_pkg::SPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            opcode <= 8'h00;
            addr_cnt <= 2'h0;
            read_status <= 1'b0;
        end else if (state == spc_pkg::SPC_IDLE) begin
            addr_cnt <= 2'h0;
            read_status <= 1'b0;
        end else if (cmd_byte) begin
            opcode <= rx;
            read_status <= (rx == `SPC_OP_RDSR);
        end else if (addr_byte) begin
            addr_cnt <= addr_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sector_idx <= 4'h0;
            addr_ok <= 1'b0;
            data_ok <= 1'b0;
            wr_data <= 8'h00;
        end else if (state == spc_pkg::SPC_IDLE) begin
            addr_ok <= 1'b0;
            data_ok <= 1'b0;
        end else begin
            if (addr_byte & (addr_cnt == 2'h0)) begin
                sector_idx <= rx[`SPC_SECT_HI:`SPC_SECT_LO];
            end
            if (addr_last) begin
                addr_ok <= 1'b1;
            end
            if (data_byte) begin
                wr_data <= rx;
                data_ok <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Lock bit, write enable latch and sector protection bits
    // ------------------------------------------------------------------

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lock <= `SPC_LOCK_RST;
        end else if (wrsr_take) begin
            lock <= wr_data[`SPC_LOCK_POS];
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            write_enable_latch <= `SPC_WEL_RST;
        end else if (wel_set) begin
            write_enable_latch <= 1'b1;
        end else if (wel_clr) begin
            write_enable_latch <= 1'b0;
        end
    end

    localparam logic [15:0] prot_rst = `SPC_PROT_RST;

    genvar s;
    generate
        for (s = 0; s < `SPC_SECTORS; s = s + 1) begin : g_sect
            wire hit = (sector_idx == 4'(s));
            always_ff @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    prot[s] <= prot_rst[s];
                end else if (glb_set | (sect_set & hit)) begin
                    prot[s] <= 1'b1;
                end else if (glb_clr | (sect_clr & hit)) begin
                    prot[s] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data and serial output
    // ------------------------------------------------------------------

    wire prot_all = &prot;
    wire prot_none = ~|prot;
    wire [1:0] soft_protect_summary = prot_all ? `SPC_SWP_ALL :
                     prot_none ? `SPC_SWP_NONE : `SPC_SWP_SOME;
    wire [7:0] status_byte = {lock, 1'b0, 1'b0, wp_s, soft_protect_summary, write_enable_latch, 1'b0};
    wire [7:0] query_byte = prot[sector_idx] ? `SPC_BYTE_PROT :
                            `SPC_BYTE_UNPROT;
    wire [7:0] out_byte = read_status ? status_byte : query_byte;
    wire reading = (state == spc_pkg::SPC_READ) & link.active;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            so_out <= 1'b0;
            out_idx <= `SPC_BIT_FIRST;
        end else if (!reading) begin
            so_out <= 1'b0;
            out_idx <= `SPC_BIT_FIRST;
        end else if (link.sck_fall) begin
            so_out <= out_byte[out_idx];
            out_idx <= out_idx - 3'h1;
        end
    end

    assign so_oe_out = reading;
    assign sector_lock_bit_out = lock;
    assign write_enable_latch_out = write_enable_latch;
    assign soft_protect_summary_out = soft_protect_summary;
    assign sector_prot_out = prot;

endmodule

/* File: design/spc_map.svh */
// Offsets, field positions, reset values and opcodes of the protection block.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

`define SPC_OP_WREN 8'h06
`define SPC_OP_WRDI 8'h04
`define SPC_OP_WRSR 8'h01
`define SPC_OP_RDSR 8'h05
`define SPC_OP_PROT 8'h36
`define SPC_OP_UNPROT 8'h39
`define SPC_OP_RDPROT 8'h3c

`define SPC_SECTORS 16
`define SPC_PROT_RST 16'hffff
`define SPC_LOCK_RST 1'b0
`define SPC_WEL_RST 1'b0

`define SPC_LOCK_POS 7
`define SPC_GLB_HI 5
`define SPC_GLB_LO 2
`define SPC_GLB_ALL1 4'hf
`define SPC_GLB_ALL0 4'h0

`define SPC_ADDR_LAST 2'h2
`define SPC_SECT_HI 4
`define SPC_SECT_LO 1

`define SPC_BYTE_PROT 8'hff
`define SPC_BYTE_UNPROT 8'h00
`define SPC_BIT_FIRST 3'h7
`define SPC_BIT_LAST 3'h7

`define SPC_SWP_NONE 2'h0
`define SPC_SWP_SOME 2'h1
`define SPC_SWP_ALL 2'h3

`endif

/* File: design/spc_pkg.sv */
// Types shared by the sector protection control modules.
package spc_pkg;

    typedef enum logic [2:0] {
        SPC_IDLE = 3'h0,
        SPC_CMD = 3'h1,
        SPC_ADDR = 3'h3,
        SPC_DATA = 3'h2,
        SPC_READ = 3'h6,
        SPC_SKIP = 3'h7
    } spc_state_type;

endpackage

/* File: design/spc_link_if.sv */
// Received serial frame events passed from the shifter to the controller.
`timescale 1ns/1ps

interface spc_link_if;
    logic active;
    logic sck_fall;
    logic byte_done;
    logic frame_end;
    logic [7:0] rx_byte;

    modport src (
        output active,
        output sck_fall,
        output byte_done,
        output frame_end,
        output rx_byte
    );

    modport dst (
        input active,
        input sck_fall,
        input byte_done,
        input frame_end,
        input rx_byte
    );
endinterface

/* File: design/spc_sync.sv */
// Two-stage synchronisers for the serial bus and write-protect pins.
`timescale 1ns/1ps

module spc_sync (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [3:0] async_in,
    output logic [3:0] sync_out
);

    logic [3:0] stage1;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_bit
            always_ff @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    stage1[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    stage1[i] <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule

/* File: design/spc_shifter.sv */
// Serial receive shifter: SCK edge detection, bit count and byte strobes.
`timescale 1ns/1ps
`include "spc_map.svh"

module spc_shifter (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic sck_in,
    input wire logic si_in,
    input wire logic cs_n_in,
    spc_link_if.src link
);

    logic sck_prev;
    logic cs_prev;
    logic [2:0] bit_cnt;
    logic [6:0] shift;

    wire sck_rise = ~cs_n_in & sck_in & ~sck_prev;
    wire last_bit = sck_rise & (bit_cnt == `SPC_BIT_LAST);

    assign link.active = ~cs_n_in;
    assign link.sck_fall = ~cs_n_in & ~sck_in & sck_prev;
    assign link.frame_end = cs_n_in & ~cs_prev;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sck_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            sck_prev <= sck_in;
            cs_prev <= cs_n_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bit_cnt <= 3'h0;
            shift <= 7'h00;
        end else if (cs_n_in) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shift <= {shift[5:0], si_in};
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            link.byte_done <= 1'b0;
            link.rx_byte <= 8'h00;
        end else begin
            link.byte_done <= last_bit;
            if (last_bit) begin
                link.rx_byte <= {shift, si_in};
            end
        end
    end

endmodule

/* File: verif/spc_top_sva.sv */
// Concurrent checks on the ports of the sector protection block.
`timescale 1ns/1ps

module spc_top_sva (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic cs_n_in,
    input wire logic wp_n_in,
    input wire logic so_oe_out,
    input wire logic sector_lock_bit_out,
    input wire logic write_enable_latch_out,
    input wire logic [1:0] soft_protect_summary_out,
    input wire logic [15:0] sector_prot_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    a_summary_all: assert property (
        (&sector_prot_out) |-> soft_protect_summary_out == 2'h3)
        else $error("summary not all when every sector protected");
    a_summary_none: assert property (
        sector_prot_out == 16'h0 |-> soft_protect_summary_out == 2'h0)
        else $error("summary not none when no sector protected");
    a_summary_some: assert property (
        sector_prot_out != 16'h0 && sector_prot_out != 16'hffff
        |-> soft_protect_summary_out == 2'h1)
        else $error("summary not some for a mixed pattern");
    a_oe_released: assert property (
        cs_n_in [*4] |-> !so_oe_out)
        else $error("output enable held after select release");
    a_hw_lock_hold: assert property (
        (!wp_n_in) [*4] ##0 sector_lock_bit_out
        |=> sector_lock_bit_out && $stable(sector_prot_out))
        else $error("hardware lock did not freeze lock or sectors");
    a_soft_lock_freeze: assert property (
        sector_lock_bit_out && $past(sector_lock_bit_out)
        |-> $stable(sector_prot_out))
        else $error("sector bits changed while locked");
    a_global_only: assert property (
        $countones(sector_prot_out ^ $past(sector_prot_out)) > 1
        |-> (&sector_prot_out) || sector_prot_out == 16'h0)
        else $error("multi bit change was not a global action");
    a_prot_needs_wel: assert property (
        sector_prot_out != $past(sector_prot_out)
        |-> $past(write_enable_latch_out))
        else $error("sector bits changed without write enable");
    a_lock_needs_wel: assert property (
        $changed(sector_lock_bit_out) |-> $past(write_enable_latch_out))
        else $error("lock bit changed without write enable");
endmodule

/* File: verif/spc_host.sv */
// Host serial controller model driving select, clock and data in.
`timescale 1ns/1ps

module spc_host (
    input wire logic clk_sys_in,
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out
);
    logic [7:0] rx;

    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        rx = 8'h00;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    // ------------------------------------------------------------
    // Byte shifting, MSB first; a released output reads inverted.
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] tx, input int nbits);
        for (int i = 7; i > 7 - nbits; i--) begin
            sck_out <= 1'b0;
            si_out <= tx[i];
            wait_clk(4);
            sck_out <= 1'b1;
            wait_clk(4);
            rx[i] = so_oe_in ? so_in : ~rx[i];
        end
    endtask

    task automatic start();
        cs_n_out <= 1'b0;
        wait_clk(4);
    endtask

    task automatic stop();
        sck_out <= 1'b0;
        wait_clk(4);
        cs_n_out <= 1'b1;
        si_out <= ~si_out;
        wait_clk(8);
    endtask

    task automatic cmd(input logic [7:0] op);
        start();
        xfer(op, 8);
        stop();
    endtask
endmodule

/* File: verif/spc_top_tb_top.sv */
// Self-checking bench for the sector protection block.
`timescale 1ns/1ps

module spc_top_tb_top;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic wp_n_in = 1'b1;
    logic cs_n, sck, si, so, so_oe, lock, write_enable_latch;
    logic [1:0] summary;
    logic [15:0] prot;
    logic [15:0] ep = 16'hffff;
    logic el = 1'b0;
    int num_errors = 0;
    int n_checks = 0;
    // Entries are pin level, write enable first, then the data byte.
    // Entry 0 is the rightmost one of the list.
    localparam logic [11:0][9:0] wr_tab = {10'h30f, 10'h3ff, 10'h300,
        10'h30f, 10'h380, 10'h100, 10'h3f0, 10'h200, 10'h37f, 10'h33c,
        10'h300, 10'h324};

    always #12.5 clk_sys_in = ~clk_sys_in;

    spc_top i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .cs_n_in(cs_n), .sck_in(sck), .si_in(si), .wp_n_in(wp_n_in),
        .so_out(so), .so_oe_out(so_oe), .sector_lock_bit_out(lock),
        .write_enable_latch_out(write_enable_latch), .soft_protect_summary_out(summary),
        .sector_prot_out(prot));

    spc_host i_host (.clk_sys_in(clk_sys_in), .so_in(so), .so_oe_in(so_oe),
        .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic status();
        logic [1:0] es;
        logic [15:0] seen;
        es = (ep == 16'hffff) ? 2'h3 : (ep == 16'h0) ? 2'h0 : 2'h1;
        i_host.start();
        i_host.xfer(8'h05, 8);
        i_host.xfer(8'h00, 8);
        i_host.stop();
        seen = {11'h0, i_host.rx[7], i_host.rx[4:2], i_host.rx[1]};
        check("status", seen, {11'h0, el, wp_n_in, es, 1'b0});
        check("summary", {14'h0, summary}, {14'h0, es});
    endtask

    task automatic wrsr(input logic [9:0] t);
        logic [7:0] d;
        d = t[7:0];
        wp_n_in <= t[9];
        i_host.wait_clk(4);
        if (t[8])
            i_host.cmd(8'h06);
        i_host.start();
        i_host.xfer(8'h01, 8);
        i_host.xfer(d, 8);
        i_host.stop();
        if (t[8] && !(!t[9] && el)) begin
            if (!el && d[5:2] == 4'hf)
                ep = 16'hffff;
            if (!el && d[5:2] == 4'h0)
                ep = 16'h0;
            el = d[7];
        end
        check("prot", prot, ep);
        check("lock", {15'h0, lock}, {15'h0, el});
        check("wel", {15'h0, write_enable_latch}, 16'h0);
        status();
    endtask

    task automatic sect(input logic [7:0] op, input logic [3:0] s,
        input logic en);
        if (en)
            i_host.cmd(8'h06);
        i_host.start();
        i_host.xfer(op, 8);
        i_host.xfer({3'h7, s, 1'b1}, 8);
        i_host.xfer(8'hff, 8);
        i_host.xfer(8'hff, 8);
        i_host.stop();
        if (en && !el)
            ep[s] = (op == 8'h36);
        check("sect", prot, ep);
        check("wel", {15'h0, write_enable_latch}, 16'h0);
    endtask

    task automatic query(input logic [3:0] s, input logic wp);
        logic [15:0] exp;
        logic [7:0] b0;
        wp_n_in <= wp;
        exp = ep[s] ? 16'hffff : 16'h0;
        i_host.start();
        i_host.xfer(8'h3c, 8);
        i_host.xfer({3'h7, s, 1'b1}, 8);
        i_host.xfer(8'hff, 8);
        i_host.xfer(8'hff, 8);
        i_host.xfer(8'h00, 8);
        b0 = i_host.rx;
        i_host.xfer(8'h00, 8);
        check("query", {b0, i_host.rx}, exp);
        i_host.xfer(8'h00, 3);
        i_host.stop();
        check("query_oe", {15'h0, so_oe}, 16'h0);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        i_host.wait_clk(4);
        check("prot", prot, 16'hffff);
        check("lock", {15'h0, lock}, 16'h0);
        for (int i = 0; i < 12; i++)
            wrsr(wr_tab[i]);
        sect(8'h39, 4'h5, 1'b1);
        status();
        for (int i = 4; i < 7; i++)
            query(i[3:0], ~i[0]);
        i_host.cmd(8'h06);
        check("wel", {15'h0, write_enable_latch}, 16'h1);
        i_host.cmd(8'h04);
        check("wel", {15'h0, write_enable_latch}, 16'h0);
        wrsr(10'h3f0);
        sect(8'h39, 4'h4, 1'b1);
        nrst_in <= 1'b0;
        i_host.wait_clk(3);
        nrst_in <= 1'b1;
        i_host.wait_clk(4);
        ep = 16'hffff;
        el = 1'b0;
        check("prot", prot, ep);
        check("lock", {15'h0, lock}, 16'h0);
        sect(8'h39, 4'h3, 1'b1);
        sect(8'h36, 4'h3, 1'b1);
        sect(8'h39, 4'h2, 1'b0);
        query(4'h3, 1'b1);
        results();
    end

    initial begin
        repeat (60000) @(posedge clk_sys_in);
        num_errors++;
        results();
    end
endmodule

bind spc_top spc_top_sva i_sva (.clk_sys_in, .nrst_in, .cs_n_in, .wp_n_in,
    .so_oe_out, .sector_lock_bit_out, .write_enable_latch_out,
    .soft_protect_summary_out, .sector_prot_out);
